/* rtl/pcx_pkg.sv */
// package for the priority crossbar pin assigner: pin and signal indices, field layouts
// assumes a single system clock domain and plain configuration ports, no register bus
//
// Summary of operation
// - only pins P0.0 to P2.6 used; fixed pins used even if skipped
// - select inputs choose participating peripheral signals
// - fixed priority order across all peripheral signals
// - serial port always on P0.4, P0.5
// - radio SPI always on P1.0 to P1.2
// - P1.3 radio slave select only four-wire
// - others take lowest free unskipped pin
// - skipped or taken pins are passed over
// - skip bit n maps to pin n
// - crossbar disabled holds all drivers off
// - bus data and clock forced open-drain
// - general SPI slave select only four-wire
// - general SPI wire mode shifts later pins
// - skipped pin never claimed by a flexible signal

package pcx_pkg;

	// ***************************************************
	// pin and signal space
	// ***************************************************
	localparam int NUM_PINS    = 23;
	localparam int NUM_SIGS    = 26;
	localparam int PINS_PER_PORT = 8;
	localparam int NUM_CEX     = 6;

	localparam logic [4:0] PIN_UART_TX    = 5'h04;
	localparam logic [4:0] PIN_UART_RX    = 5'h05;
	localparam logic [4:0] PIN_RADIO_SCK  = 5'h08;
	localparam logic [4:0] PIN_RADIO_MISO = 5'h09;
	localparam logic [4:0] PIN_RADIO_MOSI = 5'h0a;
	localparam logic [4:0] PIN_RADIO_NSS  = 5'h0b;

	// signal indices in priority order
	localparam logic [4:0] SIG_UART_TX    = 5'h00;
	localparam logic [4:0] SIG_UART_RX    = 5'h01;
	localparam logic [4:0] SIG_RADIO_SCK  = 5'h02;
	localparam logic [4:0] SIG_RADIO_MISO = 5'h03;
	localparam logic [4:0] SIG_RADIO_MOSI = 5'h04;
	localparam logic [4:0] SIG_RADIO_NSS  = 5'h05;
	localparam logic [4:0] SIG_GEN_SCK    = 5'h06;
	localparam logic [4:0] SIG_GEN_MISO   = 5'h07;
	localparam logic [4:0] SIG_GEN_MOSI   = 5'h08;
	localparam logic [4:0] SIG_GEN_NSS    = 5'h09;
	localparam logic [4:0] SIG_SDA        = 5'h0a;
	localparam logic [4:0] SIG_SCL        = 5'h0b;
	localparam logic [4:0] SIG_CMP_A      = 5'h0c;
	localparam logic [4:0] SIG_CMP_A_ASYN = 5'h0d;
	localparam logic [4:0] SIG_CMP_B      = 5'h0e;
	localparam logic [4:0] SIG_CMP_B_ASYN = 5'h0f;
	localparam logic [4:0] SIG_SYSTEM_CLOCK_OUTPUT_OUT = 5'h10;
	localparam logic [4:0] SIG_CEX_FIRST  = 5'h11;
	localparam logic [4:0] SIG_ECI        = 5'h17;
	localparam logic [4:0] SIG_TIMER_A    = 5'h18;
	localparam logic [4:0] SIG_TIMER_B    = 5'h19;
	localparam logic [4:0] SIG_FIRST_FLEX = SIG_GEN_SCK;

	localparam logic [1:0] SSM_THREE_WIRE = 2'h0;
	localparam logic [NUM_PINS-1:0] RESET_PINS = 23'h000000;
	localparam logic [NUM_SIGS-1:0] RESET_SIGS = 26'h0000000;
	localparam logic NOT_ROUTED_IN = 1'h1;

	// ***************************************************
	// carriers
	// ***************************************************
	// select bits gathered from the three crossbar select registers
	typedef struct packed {
		logic       uartEn;
		logic       radioSpiEn;
		logic       radioSpiFourWire;
		logic       generalSpiEn;
		logic       smbusEn;
		logic       cmpAEn;
		logic       cmpAAsyncEn;
		logic       cmpBEn;
		logic       cmpBAsyncEn;
		logic       sysclkOutEn;
		logic [2:0] cexCount;
		logic       eciEn;
		logic       timerAEn;
		logic       timerBEn;
	} pcx_select_t;

	typedef struct packed {
		logic [7:0] port0;
		logic [7:0] port1;
		logic [7:0] port2;
	} pcx_skip_t;

endpackage

/* rtl/pcx_crossbar.sv */
// priority crossbar pin assigner: maps selected peripheral signals onto port pins
// assumes config ports and peripheral signals are on sys_clk; pad inputs are asynchronous

`timescale 1ns/10ps
`default_nettype none

module pcx_crossbar #(
	parameter int NP = pcx_pkg::NUM_PINS,
	parameter int NS = pcx_pkg::NUM_SIGS
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// configuration
	input  wire pcx_pkg::pcx_select_t crossbarSelect,
	input  wire pcx_pkg::pcx_skip_t   pinSkipMask,
	input  wire logic                 crossbarGlobalEnable,
	input  wire logic [1:0]           slaveSelectModeField,
	input  wire logic [NP-1:0]        pinOutputMode,
	input  wire logic [NP-1:0]        portLatch,
	// peripheral side
	input  wire logic [NS-1:0]        periphOut,
	input  wire logic [NS-1:0]        periphOe,
	output logic      [NS-1:0]        periphIn,
	// pad side
	input  wire logic [NP-1:0]        pinIn,
	output logic      [NP-1:0]        pinOut,
	output logic      [NP-1:0]        pinOe,
	// status
	output logic      [NP-1:0]        pinAssigned
);

	// ***************************************************
	// request vector and skip flattening
	// ***************************************************
	logic [NS-1:0] sigReq;
	logic [NP-1:0] skipFlat;
	logic          genFourWire;

	assign genFourWire = slaveSelectModeField != pcx_pkg::SSM_THREE_WIRE;
	assign skipFlat    = {pinSkipMask.port2[6:0], pinSkipMask.port1, pinSkipMask.port0};

	always_comb begin
		sigReq = '0;
		sigReq[pcx_pkg::SIG_UART_TX]    = crossbarSelect.uartEn;
		sigReq[pcx_pkg::SIG_UART_RX]    = crossbarSelect.uartEn;
		sigReq[pcx_pkg::SIG_RADIO_SCK]  = crossbarSelect.radioSpiEn;
		sigReq[pcx_pkg::SIG_RADIO_MISO] = crossbarSelect.radioSpiEn;
		sigReq[pcx_pkg::SIG_RADIO_MOSI] = crossbarSelect.radioSpiEn;
		sigReq[pcx_pkg::SIG_RADIO_NSS]  = crossbarSelect.radioSpiEn & crossbarSelect.radioSpiFourWire;
		sigReq[pcx_pkg::SIG_GEN_SCK]    = crossbarSelect.generalSpiEn;
		sigReq[pcx_pkg::SIG_GEN_MISO]   = crossbarSelect.generalSpiEn;
		sigReq[pcx_pkg::SIG_GEN_MOSI]   = crossbarSelect.generalSpiEn;
		sigReq[pcx_pkg::SIG_GEN_NSS]    = crossbarSelect.generalSpiEn & genFourWire;
		sigReq[pcx_pkg::SIG_SDA]        = crossbarSelect.smbusEn;
		sigReq[pcx_pkg::SIG_SCL]        = crossbarSelect.smbusEn;
		sigReq[pcx_pkg::SIG_CMP_A]      = crossbarSelect.cmpAEn;
		sigReq[pcx_pkg::SIG_CMP_A_ASYN] = crossbarSelect.cmpAAsyncEn;
		sigReq[pcx_pkg::SIG_CMP_B]      = crossbarSelect.cmpBEn;
		sigReq[pcx_pkg::SIG_CMP_B_ASYN] = crossbarSelect.cmpBAsyncEn;
		sigReq[pcx_pkg::SIG_SYSTEM_CLOCK_OUTPUT_OUT] = crossbarSelect.sysclkOutEn;
		for (int k = 0; k < pcx_pkg::NUM_CEX; k++) begin
			sigReq[int'(pcx_pkg::SIG_CEX_FIRST) + k] = 32'(crossbarSelect.cexCount) > k;
		end
		sigReq[pcx_pkg::SIG_ECI]        = crossbarSelect.eciEn;
		sigReq[pcx_pkg::SIG_TIMER_A]    = crossbarSelect.timerAEn;
		sigReq[pcx_pkg::SIG_TIMER_B]    = crossbarSelect.timerBEn;
	end

	// ***************************************************
	// priority decode
	// ***************************************************
	// a pure function of the present settings; the whole map is rebuilt every cycle
	logic [NP-1:0]   pinUsedNext;
	logic [4:0]      pinSigNext [NP];
	logic [NS-1:0]   sigRoutedNext;
	logic [4:0]      sigPinNext [NS];

	always_comb begin
		logic found;
		found = 1'b0;
		pinUsedNext   = '0;
		sigRoutedNext = '0;
		for (int p = 0; p < NP; p++) pinSigNext[p] = '0;
		for (int s = 0; s < NS; s++) sigPinNext[s] = '0;
		// fixed pins first, ahead of every flexible signal
		for (int s = 0; s < int'(pcx_pkg::SIG_FIRST_FLEX); s++) begin
			if (sigReq[s]) begin
				sigPinNext[s] = (s == 0) ? pcx_pkg::PIN_UART_TX :
				                (s == 1) ? pcx_pkg::PIN_UART_RX :
				                (s == 2) ? pcx_pkg::PIN_RADIO_SCK :
				                (s == 3) ? pcx_pkg::PIN_RADIO_MISO :
				                (s == 4) ? pcx_pkg::PIN_RADIO_MOSI : pcx_pkg::PIN_RADIO_NSS;
				sigRoutedNext[s] = 1'b1;
				pinUsedNext[sigPinNext[s]] = 1'b1;
				pinSigNext[sigPinNext[s]]  = 5'(s);
			end
		end
		// remaining signals in priority order take the lowest free pin
		for (int s = int'(pcx_pkg::SIG_FIRST_FLEX); s < NS; s++) begin
			found = 1'b0;
			for (int p = 0; p < NP; p++) begin
				if (sigReq[s] && !found && !pinUsedNext[p] && !skipFlat[p]) begin
					found            = 1'b1;
					pinUsedNext[p]   = 1'b1;
					pinSigNext[p]    = 5'(s);
					sigPinNext[s]    = 5'(p);
					sigRoutedNext[s] = 1'b1;
				end
			end
		end
	end

	logic [NP-1:0] pinUsedReg;
	logic [4:0]    pinSigReg [NP];
	logic [NS-1:0] sigRoutedReg;
	logic [4:0]    sigPinReg [NS];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pinUsedReg   <= pcx_pkg::RESET_PINS;
			sigRoutedReg <= pcx_pkg::RESET_SIGS;
			for (int p = 0; p < NP; p++) pinSigReg[p] <= '0;
			for (int s = 0; s < NS; s++) sigPinReg[s] <= '0;
		end else begin
			pinUsedReg   <= pinUsedNext;
			sigRoutedReg <= sigRoutedNext;
			pinSigReg    <= pinSigNext;
			sigPinReg    <= sigPinNext;
		end
	end

	// ***************************************************
	// pad drive and input return
	// ***************************************************
	logic [NP-1:0] pinMeta;
	logic [NP-1:0] pinSync;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pinMeta <= pcx_pkg::RESET_PINS;
			pinSync <= pcx_pkg::RESET_PINS;
		end else begin
			pinMeta <= pinIn;
			pinSync <= pinMeta;
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_pin
			logic sigVal;
			logic sigDrv;
			logic openDrain;
			assign sigVal    = periphOut[pinSigReg[gp]];
			assign sigDrv    = periphOe[pinSigReg[gp]];
			assign openDrain = !pinOutputMode[gp] || pinSigReg[gp] == pcx_pkg::SIG_SDA
			                   || pinSigReg[gp] == pcx_pkg::SIG_SCL;
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					pinOut[gp] <= 1'b0;
					pinOe[gp]  <= 1'b0;
				end else if (!crossbarGlobalEnable) begin
					pinOut[gp] <= 1'b0;
					pinOe[gp]  <= 1'b0;
				end else if (pinUsedReg[gp]) begin
					pinOut[gp] <= openDrain ? 1'b0 : sigVal;
					pinOe[gp]  <= openDrain ? (sigDrv & ~sigVal) : sigDrv;
				end else begin
					pinOut[gp] <= pinOutputMode[gp] ? portLatch[gp] : 1'b0;
					pinOe[gp]  <= pinOutputMode[gp] | ~portLatch[gp];
				end
			end
		end
	endgenerate

	// unrouted peripheral inputs idle high so a receiver sees no traffic
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			periphIn    <= {NS{pcx_pkg::NOT_ROUTED_IN}};
			pinAssigned <= pcx_pkg::RESET_PINS;
		end else begin
			for (int s = 0; s < NS; s++) begin
				periphIn[s] <= sigRoutedReg[s] ? pinSync[sigPinReg[s]] : pcx_pkg::NOT_ROUTED_IN;
			end
			pinAssigned <= pinUsedReg;
		end
	end

	// ***************************************************
	// checks
	// ***************************************************
	// skip mask as it stood when the present map was built, so the gap check lines up with pinUsedReg
	logic [NP-1:0] skipPrevReg;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			skipPrevReg <= pcx_pkg::RESET_PINS;
		end else begin
			skipPrevReg <= skipFlat;
		end
	end

	// a used flexible pin above a free eligible pin means the search was not lowest-first
	logic gapSeen;
	always_comb begin
		logic freeBelow;
		freeBelow = 1'b0;
		gapSeen   = 1'b0;
		for (int p = 0; p < NP; p++) begin
			if (pinUsedReg[p] && pinSigReg[p] >= pcx_pkg::SIG_FIRST_FLEX && freeBelow) gapSeen = 1'b1;
			if (!pinUsedReg[p] && !skipPrevReg[p]) freeBelow = 1'b1;
		end
	end

	uart_fixed_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		crossbarSelect.uartEn |=> pinUsedReg[pcx_pkg::PIN_UART_TX] && pinSigReg[pcx_pkg::PIN_UART_TX] == 5'h00
		&& pinSigReg[pcx_pkg::PIN_UART_RX] == pcx_pkg::SIG_UART_RX)
		else $error("serial port not on its fixed pins");
	radio_fixed_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		crossbarSelect.radioSpiEn |=> pinSigReg[pcx_pkg::PIN_RADIO_SCK] == pcx_pkg::SIG_RADIO_SCK
		&& pinSigReg[pcx_pkg::PIN_RADIO_MOSI] == pcx_pkg::SIG_RADIO_MOSI)
		else $error("radio spi not on its fixed pins");
	radio_nss_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		crossbarSelect.radioSpiEn |=> (pinSigReg[pcx_pkg::PIN_RADIO_NSS] == pcx_pkg::SIG_RADIO_NSS)
		== $past(crossbarSelect.radioSpiFourWire))
		else $error("radio slave select pin wrong for wire mode");
	skip_respected_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> (pinUsedReg & $past(skipFlat) & ~23'h000f30) == '0)
		else $error("skipped pin claimed");
	lowest_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(rst_n) |-> !gapSeen)
		else $error("free pin passed over");
	gen_nss_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		slaveSelectModeField == pcx_pkg::SSM_THREE_WIRE |=> !sigRoutedReg[pcx_pkg::SIG_GEN_NSS])
		else $error("slave select routed in three-wire mode");
	unselected_free_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!crossbarSelect.smbusEn |=> !sigRoutedReg[pcx_pkg::SIG_SDA] && !sigRoutedReg[pcx_pkg::SIG_SCL])
		else $error("unselected peripheral holds a pin");
	drivers_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!crossbarGlobalEnable |=> pinOe == '0)
		else $error("driver on while crossbar disabled");
	bus_open_drain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		crossbarGlobalEnable && sigRoutedReg[pcx_pkg::SIG_SDA] |=> pinOut[$past(sigPinReg[pcx_pkg::SIG_SDA])] == 1'b0)
		else $error("bus data pin driven high");
	gpio_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		crossbarGlobalEnable && !pinUsedReg[0] && pinOutputMode[0] |=> pinOe[0] && pinOut[0] == $past(portLatch[0]))
		else $error("free pin not driven from latch");

endmodule // pcx_crossbar

`default_nettype wire

/* verif/pcx_pad_model.sv */
// pad-side partner: resolves each pin from crossbar drive, a board driver and a pull-up
// assumes every pad has a weak pull-up, so an undriven pad reads high
`timescale 1ns/10ps
`default_nettype none

module pcx_pad_model #(
	parameter int NP = pcx_pkg::NUM_PINS
) (
	// from the crossbar
	input  wire logic [NP-1:0] pinOut,
	input  wire logic [NP-1:0] pinOe,
	// board driver
	input  wire logic [NP-1:0] extVal,
	input  wire logic [NP-1:0] extEn,
	// to the crossbar
	output logic      [NP-1:0] pinIn
);
	// crossbar drive wins, then the board; released pads go to the pull-up, never the last value
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'h1);
		end
	end
endmodule // pcx_pad_model

`default_nettype wire

/* verif/pcx_crossbar_bench.sv */
// self-checking bench for the priority crossbar pin assigner
// assumes the pad model in pcx_pad_model.sv; peripheral signals are driven here directly
`timescale 1ns/10ps
`default_nettype none

module pcx_crossbar_bench;
	localparam int NP = pcx_pkg::NUM_PINS;
	localparam int NS = pcx_pkg::NUM_SIGS;
	// ***************************************************
	// signals
	// ***************************************************
	logic                 sys_clk  = 1'h0;
	logic                 rst_n    = 1'h0;
	pcx_pkg::pcx_select_t sel      = '0;
	pcx_pkg::pcx_skip_t   skip     = '0;
	logic                 xbarEn   = 1'h1;
	logic [1:0]           ssMode   = 2'h0;
	logic [NP-1:0]        outMode  = '1;
	logic [NP-1:0]        latch    = '0;
	logic [NS-1:0]        pOut     = '0;
	logic [NS-1:0]        pOe      = '1;
	logic [NP-1:0]        extVal   = '0;
	logic [NP-1:0]        extEn    = '0;
	logic [NS-1:0]        pIn;
	logic [NP-1:0]        pinIn;
	logic [NP-1:0]        pinOut;
	logic [NP-1:0]        pinOe;
	logic [NP-1:0]        pinAssigned;
	int                   n_fail   = 0;
	int                   compares = 0;
	int                   cycles   = 0;

	always #25 sys_clk = ~sys_clk;

	pcx_crossbar dut (.sys_clk(sys_clk), .rst_n(rst_n), .crossbarSelect(sel), .pinSkipMask(skip),
		.crossbarGlobalEnable(xbarEn), .slaveSelectModeField(ssMode), .pinOutputMode(outMode),
		.portLatch(latch), .periphOut(pOut), .periphOe(pOe), .periphIn(pIn), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pinAssigned(pinAssigned));
	pcx_pad_model pads (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

	// ***************************************************
	// shared tasks
	// ***************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// inputs always change 1 ns after a rising edge
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_reset();
		settle(6);
		chk("reset pinOe", '0, pinOe);
		chk("reset pinAssigned", '0, pinAssigned);
		chk("reset periphIn", {NS{1'h1}}, pIn);
		rst_n = 1'h1;
	endtask

	task automatic t_fixed();
		sel = '0;
		sel.uartEn = 1'h1;
		settle(3);
		chk("uart pins", 23'h000030, pinAssigned);
		sel = '0;
		sel.radioSpiEn = 1'h1;
		settle(3);
		chk("radio three-wire", 23'h000700, pinAssigned);
		sel.radioSpiFourWire = 1'h1;
		settle(3);
		chk("radio four-wire", 23'h000f00, pinAssigned);
	endtask

	// pins 2 and 3 skipped for the oscillator, fixed pins left clear
	task automatic t_skip();
		sel = '0;
		sel.uartEn = 1'h1;
		sel.generalSpiEn = 1'h1;
		sel.smbusEn = 1'h1;
		skip.port0 = 8'h0c;
		settle(3);
		chk("spi three-wire skip", 23'h0001f3, pinAssigned);
		ssMode = 2'h1;
		settle(3);
		chk("spi four-wire skip", 23'h0003f3, pinAssigned);
		pOut = '1;
		settle(2);
		chk("sda released high", 2'h0, {pinOe[8], pinOut[8]});
		pOut = '0;
		settle(2);
		chk("sda pulled low", 2'h2, {pinOe[8], pinOut[8]});
		skip = '0;
		ssMode = 2'h0;
	endtask

	// every flexible function selected, one counter channel, nothing skipped
	task automatic t_order();
		logic [4:0] sigs [14] = '{5'h06, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11,
			5'h17, 5'h18, 5'h19};
		sel = '1;
		sel.uartEn = 1'h0;
		sel.radioSpiEn = 1'h0;
		sel.cexCount = 3'h1;
		settle(3);
		chk("flex assigned", 23'h003fff, pinAssigned);
		for (int i = 0; i < 11; i++) begin
			if (i != 3 && i != 4) begin
				pOut = '0;
				pOut[sigs[i]] = 1'h1;
				settle(2);
				chk("flex pin drive", 32'h1 << i, pinOut);
			end
		end
		pOut = '0;
		pOe[24] = 1'h0;
		extEn[12] = 1'h1;
		settle(5);
		chk("timer input low", 1'h0, pIn[24]);
		chk("rx unrouted", 1'h1, pIn[1]);
		extVal[12] = 1'h1;
		settle(5);
		chk("timer input high", 1'h1, pIn[24]);
		extEn = '0;
		pOe = '1;
	endtask

	task automatic t_enable();
		latch = '1;
		xbarEn = 1'h0;
		settle(3);
		chk("disabled oe", '0, pinOe);
		xbarEn = 1'h1;
		sel = '0;
		latch = 23'h2a55aa;
		settle(3);
		chk("gpio assigned", '0, pinAssigned);
		chk("gpio push-pull out", 23'h2a55aa, pinOut);
		chk("gpio push-pull oe", 23'h7fffff, pinOe);
		outMode = '0;
		settle(2);
		chk("gpio open-drain oe", 23'h55aa55, pinOe);
	endtask

	// ***************************************************
	// main sequence and hang guard
	// ***************************************************
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		t_reset();
		t_fixed();
		t_skip();
		t_order();
		t_enable();
		print_verdict();
	end
endmodule // pcx_crossbar_bench

`default_nettype wire
